// ===== rtl/cdf_top.sv
// Per-channel diagnostic flags: dimming toggle, headroom, current, bootstrap
`timescale 1ns/10ps
`include "cdf_defines.svh"

// Summary of operation
// - Toggle register: bits 2..0 are channel 3..1 flags; bit 6 reads one.
// - A toggle flag sets on any rising or falling edge of its dimming input.
// - Any write to the toggle register clears all toggle flags without an edge that cycle.
// - Channel on and input good with low headroom: gate low, flag set.
// - Gate switching resumes once headroom is sufficient again.
// - Headroom flags stay set until the headroom register is written.
// - Cleared while idle, a headroom flag may reset from the last sample.
// - Cycle current-reached flag sets when the target current is reached.
// - It clears on dimming fall, input undervoltage or a copy request.
// - It clears when gate stays high over 1 ms with dimming input high.
// - Register 0x35: reached flags bits 5..3, headroom bits 2..0, rest 0.
// - Switch node off and bootstrap below threshold blocks gate turn-on.
// - Bootstrap undervoltage turns the channel off and sets its flag.
// - Writing one clears a bootstrap flag, zero does nothing; re-enables.
// - Bootstrap register: bits 2..0 channel 3..1 flags, bits 7..3 zero.
// - Copy request latches reached status, clears cycle flag, self-clears.
// - Dimming falling edge latches the last-cycle reached status.
module cdf_top #(
  parameter int GATE_HOLD_CYC = `CDF_GATE_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`CDF_NCH-1:0] dimming_input,
  input wire logic input_voltage_good,
  input wire logic [`CDF_NCH-1:0] channel_on,
  input wire logic [`CDF_NCH-1:0] gate_request,
  input wire logic [`CDF_NCH-1:0] headroom_low,
  input wire logic [`CDF_NCH-1:0] target_reached,
  input wire logic [`CDF_NCH-1:0] bootstrap_below_threshold,
  input wire logic [`CDF_NCH-1:0] switch_node_off,
  input wire logic [`CDF_ADDR_W-1:0] reg_addr,
  input wire logic [`CDF_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CDF_DATA_W-1:0] reg_rdata,
  output logic [`CDF_NCH-1:0] gate_drive,
  output logic [`CDF_NCH-1:0] last_cycle_reached,
  output logic [`CDF_NCH-1:0] headroom_flag,
  output logic [`CDF_NCH-1:0] cycle_current_reached,
  output logic [`CDF_NCH-1:0] bootstrap_low_flag,
  output logic [`CDF_NCH-1:0] dimming_toggled
);

  localparam int NCH = `CDF_NCH;
  localparam int NSYNC = 5 * NCH;
  localparam cdf_pkg::cdf_cnt_t HOLD_LIM = cdf_pkg::cdf_cnt_t'(GATE_HOLD_CYC);

  initial begin
    if (GATE_HOLD_CYC < 1 || GATE_HOLD_CYC >= (1 << `CDF_TMO_W)) begin
      $error("cdf_top: GATE_HOLD_CYC out of counter range");
    end
  end

  function automatic logic hit(
    input logic strobe,
    input logic [`CDF_ADDR_W-1:0] addr,
    input logic [`CDF_ADDR_W-1:0] target
  );
    hit = strobe && (addr == target);
  endfunction

  cdf_pkg::cdf_state_t st_q;
  cdf_pkg::cdf_state_t st_d;

  cdf_pkg::cdf_ch_t dim_s;
  cdf_pkg::cdf_ch_t hrl_s;
  cdf_pkg::cdf_ch_t tgt_s;
  cdf_pkg::cdf_ch_t bsl_s;
  cdf_pkg::cdf_ch_t swo_s;
  logic [NSYNC-1:0] raw_bus;
  logic [NSYNC-1:0] sync_bus;

  // Pins and analog comparators are asynchronous to clk_sys
  assign raw_bus = {dimming_input, headroom_low, target_reached,
                    bootstrap_below_threshold, switch_node_off};
  assign {dim_s, hrl_s, tgt_s, bsl_s, swo_s} = sync_bus;

  cdf_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(raw_bus),
    .sync_out(sync_bus)
  );

  always_comb begin
    logic wr_togl;
    logic wr_hrcr;
    logic wr_boot;
    logic wr_copy;
    logic vin_fall;
    logic monitor;
    logic dim_edge;
    logic dim_fall;
    logic hold_over;
    logic cr_clear;
    logic hr_set;
    logic bs_set;
    logic hr_block;
    logic bs_block;
    wr_togl = hit(reg_wr, reg_addr, `CDF_ADDR_TOGL);
    wr_hrcr = hit(reg_wr, reg_addr, `CDF_ADDR_HRCR);
    wr_boot = hit(reg_wr, reg_addr, `CDF_ADDR_BOOT);
    wr_copy = hit(reg_wr, reg_addr, `CDF_ADDR_COPY);
    vin_fall = st_q.vin_prev && !input_voltage_good;
    monitor = 1'b0;
    dim_edge = 1'b0;
    dim_fall = 1'b0;
    hold_over = 1'b0;
    cr_clear = 1'b0;
    hr_set = 1'b0;
    bs_set = 1'b0;
    hr_block = 1'b0;
    bs_block = 1'b0;
    st_d = st_q;
    st_d.dim_prev = dim_s;
    st_d.vin_prev = input_voltage_good;

    for (int i = 0; i < NCH; i++) begin
      monitor = channel_on[i] && input_voltage_good;
      dim_edge = dim_s[i] ^ st_q.dim_prev[i];
      dim_fall = st_q.dim_prev[i] && !dim_s[i];

      // Toggle flag; an edge in the clearing cycle survives
      if (wr_togl) begin
        st_d.toggle[i] = 1'b0;
      end
      if (dim_edge) begin
        st_d.toggle[i] = 1'b1;
      end

      // Headroom: last sample kept so a clear while idle can re-arm
      if (monitor) begin
        st_d.hr_last[i] = hrl_s[i];
      end
      hr_set = monitor ? hrl_s[i] : (wr_hrcr && st_q.hr_last[i]);
      if (wr_hrcr) begin
        st_d.headroom[i] = 1'b0;
      end
      if (hr_set) begin
        st_d.headroom[i] = 1'b1;
      end
      hr_block = monitor && hrl_s[i];

      // Gate-high time with dimming high
      if (st_q.gate[i] && dim_s[i]) begin
        if (st_q.hold_cnt[i] != HOLD_LIM) begin
          st_d.hold_cnt[i] = st_q.hold_cnt[i] + 1'b1;
        end
      end else begin
        st_d.hold_cnt[i] = '0;
      end
      hold_over = st_q.hold_cnt[i] == HOLD_LIM;

      // Latched last-cycle status captures the flag before it clears
      if (dim_fall || st_q.copy_req[i]) begin
        st_d.last_reached[i] = st_q.cycle_reached[i];
      end
      cr_clear = dim_fall || vin_fall || st_q.copy_req[i] || hold_over;
      if (cr_clear) begin
        st_d.cycle_reached[i] = 1'b0;
      end
      if (tgt_s[i]) begin
        st_d.cycle_reached[i] = 1'b1;
      end

      // Copy request lives one cycle, then clears itself
      st_d.copy_req[i] = wr_copy && reg_wdata[i];

      // Bootstrap lockout; detection wins over a same-cycle clear
      bs_set = swo_s[i] && bsl_s[i];
      if (wr_boot && reg_wdata[i]) begin
        st_d.boot_low[i] = 1'b0;
      end
      if (bs_set) begin
        st_d.boot_low[i] = 1'b1;
      end
      bs_block = bs_set || st_q.boot_low[i];

      st_d.gate[i] = gate_request[i] && monitor && !hr_block && !bs_block;
    end

    // Read data is registered and held until the next read
    if (reg_rd) begin
      unique case (reg_addr)
        `CDF_ADDR_TOGL: begin
          st_d.rdata = `CDF_TOGL_FIXED
                       | {{(`CDF_DATA_W-NCH){1'b0}}, st_q.toggle};
        end
        `CDF_ADDR_HRCR: begin
          st_d.rdata = `CDF_RDATA_RST;
          st_d.rdata[`CDF_CR_LSB +: NCH] = st_q.cycle_reached;
          st_d.rdata[`CDF_HR_LSB +: NCH] = st_q.headroom;
        end
        `CDF_ADDR_BOOT: begin
          st_d.rdata = {{(`CDF_DATA_W-NCH){1'b0}}, st_q.boot_low};
        end
        `CDF_ADDR_COPY: begin
          st_d.rdata = {{(`CDF_DATA_W-NCH){1'b0}}, st_q.copy_req};
        end
        default: begin
          st_d.rdata = `CDF_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign gate_drive = st_q.gate;
  assign last_cycle_reached = st_q.last_reached;
  assign headroom_flag = st_q.headroom;
  assign cycle_current_reached = st_q.cycle_reached;
  assign bootstrap_low_flag = st_q.boot_low;
  assign dimming_toggled = st_q.toggle;

endmodule

// ===== rtl/cdf_defines.svh
// Constants of the channel diagnostic flag block
`ifndef CDF_DEFINES_SVH
`define CDF_DEFINES_SVH

`define CDF_NCH 3
`define CDF_ADDR_W 7
`define CDF_DATA_W 8

`define CDF_ADDR_COPY 7'h06
`define CDF_ADDR_BOOT 7'h34
`define CDF_ADDR_HRCR 7'h35
`define CDF_ADDR_TOGL 7'h36

`define CDF_TOGL_FIXED 8'h40
`define CDF_RDATA_RST 8'h00
`define CDF_HR_LSB 0
`define CDF_CR_LSB 3

`define CDF_GATE_HOLD_MS 1
`define CDF_CLK_KHZ 100000
`define CDF_GATE_HOLD_CYC (`CDF_GATE_HOLD_MS * `CDF_CLK_KHZ)
`define CDF_TMO_W 17

`endif

// ===== rtl/cdf_pkg.sv
// Types shared by the channel diagnostic flag block
`include "cdf_defines.svh"

package cdf_pkg;

  typedef logic [`CDF_NCH-1:0] cdf_ch_t;
  typedef logic [`CDF_TMO_W-1:0] cdf_cnt_t;

  typedef struct packed {
    cdf_ch_t dim_prev;
    logic vin_prev;
    cdf_ch_t toggle;
    cdf_ch_t headroom;
    cdf_ch_t hr_last;
    cdf_ch_t cycle_reached;
    cdf_ch_t last_reached;
    cdf_ch_t boot_low;
    cdf_ch_t copy_req;
    cdf_ch_t gate;
    logic [`CDF_DATA_W-1:0] rdata;
    cdf_cnt_t [`CDF_NCH-1:0] hold_cnt;
  } cdf_state_t;

endpackage

// ===== rtl/cdf_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps

module cdf_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage2;
    logic [W-1:0] stage1;
  } cdf_sync_state_t;

  cdf_sync_state_t st_q;
  cdf_sync_state_t st_d;

  initial begin
    if (W < 1) begin
      $error("cdf_sync: width must be at least 1");
    end
  end

  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.stage1 = async_in;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stage2;

endmodule

// ===== dv/cdf_mcu_model.sv
// Register-port master standing in for the microcontroller
`timescale 1ns/10ps
module cdf_mcu_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // Serial framing is not modelled: one strobe stands for one frame
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
endmodule

// ===== dv/cdf_monitor.sv
// Checker for the diagnostic flag block ports
`timescale 1ns/10ps
module cdf_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic input_voltage_good,
  input wire logic [2:0] channel_on,
  input wire logic [2:0] gate_request,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] gate_drive,
  input wire logic [2:0] headroom_flag,
  input wire logic [2:0] cycle_current_reached,
  input wire logic [2:0] bootstrap_low_flag,
  input wire logic [2:0] dimming_toggled
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  toggle_read_a:
    assert property (reg_rd && reg_addr == 7'h36 |=>
      reg_rdata == {5'h08, $past(dimming_toggled)}) else $error("tog rd");
  hrcr_read_a:
    assert property (reg_rd && reg_addr == 7'h35 |=> reg_rdata ==
      {2'h0, $past(cycle_current_reached), $past(headroom_flag)})
      else $error("hrcr rd");
  boot_read_a:
    assert property (reg_rd && reg_addr == 7'h34 |=>
      reg_rdata == {5'h00, $past(bootstrap_low_flag)}) else $error("bs rd");
  toggle_keep_a:
    assert property (!(reg_wr && reg_addr == 7'h36) |=>
      (dimming_toggled & $past(dimming_toggled)) == $past(dimming_toggled))
      else $error("tog lost");
  headroom_keep_a:
    assert property (!(reg_wr && reg_addr == 7'h35) |=>
      (headroom_flag & $past(headroom_flag)) == $past(headroom_flag))
      else $error("hr lost");
  boot_block_a:
    assert property ((gate_drive & bootstrap_low_flag) == 3'h0)
      else $error("bs gate");
  // Gate may only follow its same-domain enables one cycle late
  gate_cause_a:
    assert property (1'b1 |=> (gate_drive & ~$past(gate_request &
      channel_on & {3{input_voltage_good}})) == 3'h0) else $error("gate");
  headroom_gate_a:
    assert property ((headroom_flag & ~$past(headroom_flag) & gate_drive)
      == 3'h0) else $error("hr gate");
endmodule
bind cdf_top cdf_monitor cdf_monitor_i (.clk_sys, .rst_n,
  .input_voltage_good, .channel_on, .gate_request, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .gate_drive, .headroom_flag, .cycle_current_reached,
  .bootstrap_low_flag, .dimming_toggled);

// ===== dv/cdf_tb.sv
// Self-checking bench for the diagnostic flag block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic clk_sys, rst_n, vin, wr, rd;
  logic [2:0] dim, on, req, hr, tgt, bsl, swo, gate, last, hrf, crf, bsf, tog;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, v;
  int checks, n_mismatch;
  cdf_mcu_model cdf_mcu_model_i (.clk_sys, .reg_rdata(rdata),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  // Short hold count keeps the timeout scenario brief
  cdf_top #(.GATE_HOLD_CYC(20)) cdf_top_i (.clk_sys, .rst_n,
    .dimming_input(dim), .input_voltage_good(vin), .channel_on(on),
    .gate_request(req), .headroom_low(hr), .target_reached(tgt),
    .bootstrap_below_threshold(bsl), .switch_node_off(swo),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .gate_drive(gate), .last_cycle_reached(last),
    .headroom_flag(hrf), .cycle_current_reached(crf),
    .bootstrap_low_flag(bsf), .dimming_toggled(tog));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    cdf_mcu_model_i.rd(a, v);
    `CHK(v, e)
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, dim, on, req, hr, tgt, bsl, swo} = '0;
    vin = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(7'h36, 8'h40);
    rchk(7'h35, 8'h00);
    rchk(7'h34, 8'h00);
    rchk(7'h10, 8'h00);
    @(posedge clk_sys) dim <= 3'h5;
    wt(5);
    rchk(7'h36, 8'h45);
    cdf_mcu_model_i.wr(7'h36, 8'h00);
    rchk(7'h36, 8'h40);
    @(posedge clk_sys) tgt <= 3'h7;
    wt(5);
    rchk(7'h35, 8'h38);
    @(posedge clk_sys) tgt <= 3'h0;
    cdf_mcu_model_i.wr(7'h06, 8'h01);
    wt(2);
    `CHK(last, 3'h1)
    `CHK(crf, 3'h6)
    @(posedge clk_sys) dim <= 3'h1;
    wt(5);
    `CHK(last, 3'h5)
    `CHK(crf, 3'h2)
    @(posedge clk_sys) vin <= 1'b0;
    @(posedge clk_sys) vin <= 1'b1;
    wt(5);
    `CHK(crf, 3'h0)
    @(posedge clk_sys) {on, req} <= 6'h3F;
    wt(2);
    `CHK(gate, 3'h7)
    @(posedge clk_sys) hr <= 3'h2;
    wt(5);
    `CHK(gate, 3'h5)
    @(posedge clk_sys) hr <= 3'h0;
    wt(5);
    `CHK(gate, 3'h7)
    rchk(7'h35, 8'h02);
    cdf_mcu_model_i.wr(7'h35, 8'h00);
    rchk(7'h35, 8'h00);
    @(posedge clk_sys) {swo, bsl} <= 6'h09;
    wt(5);
    `CHK(bsf, 3'h1)
    `CHK(gate, 3'h6)
    @(posedge clk_sys) {swo, bsl} <= 6'h00;
    cdf_mcu_model_i.wr(7'h34, 8'h06);
    rchk(7'h34, 8'h01);
    cdf_mcu_model_i.wr(7'h34, 8'h01);
    wt(1);
    `CHK(gate, 3'h7)
    @(posedge clk_sys) {dim, tgt} <= 6'h3F;
    wt(5);
    `CHK(crf, 3'h7)
    @(posedge clk_sys) tgt <= 3'h0;
    wt(30);
    `CHK(crf, 3'h0)
    summarize();
  end
endmodule
